//--- core/led_collision_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef LED_COLLISION_REGS_VH
`define LED_COLLISION_REGS_VH

`define REG_ADDR_W 4
`define REG_DATA_W 8

`define REG_EVENT_STATUS 4'h0
`define REG_EVENT_MASK 4'h4
`define REG_LIVE_STATE 4'h8
`define REG_CONTROL 4'hC

`define EV_COLLISION 0
`define EV_FIFO_ERROR 1
`define EV_JABBER 2
`define EV_PARTITION 3
`define EV_W 4

`define LIVE_MODE_LO 0
`define LIVE_MODE_HI 1
`define LIVE_MODE_VALID 2
`define LIVE_LOCAL_COL 3
`define LIVE_SHARED_COL 4

`define CTRL_LED_EN 0
`define CTRL_BP_EN 1
`define CTRL_W 2
`define CTRL_RESET 2'h3
`define MASK_RESET 4'h0

`define CLK_MHZ 200
`define LED_SLOT_US 50000
`define LED_SLOT_CYCLES (`LED_SLOT_US * `CLK_MHZ)
`define STRAP_SETTLE_CYCLES 2'h2

`define LED_OUT_Z 2'h0
`define LED_OUT_HI 2'h1
`define LED_OUT_LO 2'h2

`endif

//--- core/pin_sync.v
// two-flop synchroniser for a group of independent level inputs
`timescale 1ns/100ps
`include "led_collision_regs.vh"
module pin_sync #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_q;

  // only the second stage may be read
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule

//--- core/led_driver.v
// one three-state pulsed led driver, one pattern per condition
`timescale 1ns/100ps
`include "led_collision_regs.vh"
module led_driver (
  input wire clk,
  input wire rst_n,
  input wire slot_tick,
  input wire [1:0] slot_idx,
  input wire [5:1] cond,
  output reg led_o,
  output reg led_oe
);

  reg [2:0] sel_q;
  reg [2:0] sel_d;
  reg [1:0] drive;

  // ------------------------------------------------------------
  // pattern table
  // ------------------------------------------------------------
  function [1:0] pattern;
    input [2:0] sel;
    input [1:0] slot;
    begin
      case (sel)
        3'h1: pattern = slot[0] ? `LED_OUT_Z : `LED_OUT_HI;
        3'h2: pattern = slot[0] ? `LED_OUT_Z : `LED_OUT_LO;
        3'h3: pattern = slot[0] ? `LED_OUT_LO : `LED_OUT_HI;
        3'h4: pattern = slot[1] ? `LED_OUT_Z : `LED_OUT_HI;
        3'h5: pattern = slot[1] ? `LED_OUT_Z : `LED_OUT_LO;
        default: pattern = `LED_OUT_Z;
      endcase
    end
  endfunction

  // lowest numbered active condition owns the next frame
  always @*
  begin
    sel_d = 3'h0;
    if (cond[1])
      sel_d = 3'h1;
    else if (cond[2])
      sel_d = 3'h2;
    else if (cond[3])
      sel_d = 3'h3;
    else if (cond[4])
      sel_d = 3'h4;
    else if (cond[5])
      sel_d = 3'h5;
  end

  always @*
  begin
    drive = pattern(sel_q, slot_idx);
  end

  // condition latched per frame so a pattern is never cut mid-way
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_q <= 3'h0;
      led_o <= 1'b0;
      led_oe <= 1'b0;
    end
    else
    begin
      if (slot_tick && slot_idx == 2'h3)
        sel_q <= sel_d;
      led_o <= (drive == `LED_OUT_HI);
      led_oe <= (drive != `LED_OUT_Z);
    end
  end

endmodule

//--- core/repeater_led_collision_status.v
// collision detection, backplane collision signalling and led status drivers
// Function
// - a collision is declared when two or more ports receive at once or the attachment collision pair is active.
// - the local collision is signalled on the backplane port so all repeaters share one collision state.
// - the backplane collision line is open drain: only pulled low, never driven high.
// - seven led drivers: four twisted pair ports, the attachment port and two common outputs.
// - each led output switches among driven high, high impedance and driven low.
// - strap levels hi/lo select mode 0 for 00, 1 for 01, 2 for 10 and 3 for 11.
// - a low or floating strap reads as 0, so unconnected straps give mode 0.
// - the strap levels are captured at power-on or hardware reset.
// - mode 0 port leds show link, transmit, reversed polarity, receive, partitioned; attachment shows 2, 4, 5.
// - the common fault led shows collision as condition 3, and fifo error in mode 0 or jabber otherwise as condition 1.
// - mode 1 port leds show link and receive as 1 and 4; attachment shows receive as 4.
// - mode 2 port leds show link, partitioned, receive as 1, 2, 4; attachment shows 2 and 4.
// - mode 3 port leds show link, receive, partitioned as 1, 2, 3; attachment shows 2 and 3.
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`include "led_collision_regs.vh"
module repeater_led_collision_status #(
  parameter NUM_TP = 4,
  parameter SLOT_CYCLES = `LED_SLOT_CYCLES
) (
  input wire clk,
  input wire rst_b,
  input wire [NUM_TP:0] port_rx_active,
  input wire [NUM_TP-1:0] tp_link_pulse,
  input wire [NUM_TP-1:0] tp_polarity_reversed,
  input wire [NUM_TP:0] port_tx_packet,
  input wire [NUM_TP:0] port_rx_packet,
  input wire [NUM_TP:0] port_partitioned,
  input wire fifo_error,
  input wire jabber_lockup_indication,
  input wire attachment_collision_pair,
  input wire led_mode_strap_hi,
  input wire led_mode_strap_lo,
  input wire backplane_collision_line_i,
  output wire backplane_collision_line_o,
  output reg backplane_collision_line_oe,
  output wire [NUM_TP-1:0] twisted_pair_port_led_o,
  output wire [NUM_TP-1:0] twisted_pair_port_led_oe,
  output wire attachment_port_led_o,
  output wire attachment_port_led_oe,
  output wire common_fault_led_o,
  output wire common_fault_led_oe,
  output wire common_activity_led_o,
  output wire common_activity_led_oe,
  output reg local_collision,
  output reg shared_collision,
  input wire [`REG_ADDR_W-1:0] reg_addr,
  input wire [`REG_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`REG_DATA_W-1:0] reg_rdata,
  output reg irq
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg [1:0] rst_sync_q;
  wire rst_n;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire [3:0] pins_s;
  wire strap_hi_s;
  wire strap_lo_s;
  wire aui_col_s;
  wire bp_low_s;

  pin_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({!backplane_collision_line_i, attachment_collision_pair,
          led_mode_strap_hi, led_mode_strap_lo}),
    .dout(pins_s)
  );

  assign strap_lo_s = pins_s[0];
  assign strap_hi_s = pins_s[1];
  assign aui_col_s = pins_s[2];
  assign bp_low_s = pins_s[3];

  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  // straps are caught once after release, when the synchroniser has
  // filled; a mode change needs a new hardware reset
  reg [1:0] settle_q;
  reg [1:0] led_mode_q;
  reg mode_valid_q;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settle_q <= 2'h0;
      led_mode_q <= 2'h0;
      mode_valid_q <= 1'b0;
    end
    else if (!mode_valid_q)
    begin
      if (settle_q == `STRAP_SETTLE_CYCLES)
      begin
        led_mode_q <= {strap_hi_s, strap_lo_s};
        mode_valid_q <= 1'b1;
      end
      else
        settle_q <= settle_q + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // collision detection
  // ------------------------------------------------------------
  reg [2:0] rx_count;
  reg local_col_d;
  reg [`CTRL_W-1:0] ctrl_q;
  integer k;

  always @*
  begin
    rx_count = 3'h0;
    for (k = 0; k <= NUM_TP; k = k + 1)
      rx_count = rx_count + {2'h0, port_rx_active[k]};
    local_col_d = (rx_count >= 3'h2) || aui_col_s;
  end

  assign backplane_collision_line_o = 1'b0;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      local_collision <= 1'b0;
      shared_collision <= 1'b0;
      backplane_collision_line_oe <= 1'b0;
    end
    else
    begin
      local_collision <= local_col_d;
      // pull low only; the shared pull-up gives the released level
      backplane_collision_line_oe <= local_col_d && ctrl_q[`CTRL_BP_EN];
      // line inverted ahead of the sync so its reset value reads as released, not collision
      shared_collision <= local_col_d || bp_low_s;
    end
  end

  // ------------------------------------------------------------
  // led condition mapping
  // ------------------------------------------------------------
  function [5:1] port_cond;
    input [1:0] mode;
    input link;
    input tx;
    input pol;
    input rx;
    input part;
    begin
      case (mode)
        2'h0: port_cond = {part, rx, pol, tx, link};
        2'h1: port_cond = {1'b0, rx, 1'b0, 1'b0, link};
        2'h2: port_cond = {1'b0, rx, 1'b0, part, link};
        default: port_cond = {1'b0, 1'b0, part, rx, link};
      endcase
    end
  endfunction

  wire leds_on;
  wire [5:1] fault_cond;
  wire [5:1] activity_cond;
  wire [5:1] led_cond [0:NUM_TP+2];

  assign leds_on = mode_valid_q && ctrl_q[`CTRL_LED_EN];
  assign fault_cond = {1'b0, 1'b0, shared_collision, 1'b0,
                       (led_mode_q == 2'h0) ? fifo_error : jabber_lockup_indication};
  assign activity_cond = {1'b0, |port_rx_packet, 1'b0, |port_tx_packet, 1'b0};

  genvar g;
  generate
    for (g = 0; g < NUM_TP; g = g + 1)
    begin : g_tp_cond
      assign led_cond[g] = leds_on ? port_cond(led_mode_q, tp_link_pulse[g],
        port_tx_packet[g], tp_polarity_reversed[g], port_rx_packet[g],
        port_partitioned[g]) : 5'h00;
    end
  endgenerate

  // the attachment port has no link pulse or polarity condition
  assign led_cond[NUM_TP] = leds_on ? port_cond(led_mode_q, 1'b0, port_tx_packet[NUM_TP],
    1'b0, port_rx_packet[NUM_TP], port_partitioned[NUM_TP]) : 5'h00;
  assign led_cond[NUM_TP+1] = leds_on ? fault_cond : 5'h00;
  assign led_cond[NUM_TP+2] = leds_on ? activity_cond : 5'h00;

  // ------------------------------------------------------------
  // led slot timer
  // ------------------------------------------------------------
  // one shared timer keeps all seven drivers in phase
  reg [31:0] slot_cnt_q;
  reg slot_tick_q;
  reg [1:0] slot_idx_q;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slot_cnt_q <= 32'h0000_0000;
      slot_tick_q <= 1'b0;
      slot_idx_q <= 2'h0;
    end
    else
    begin
      slot_tick_q <= 1'b0;
      if (slot_cnt_q == SLOT_CYCLES - 1)
      begin
        slot_cnt_q <= 32'h0000_0000;
        slot_tick_q <= 1'b1;
      end
      else
        slot_cnt_q <= slot_cnt_q + 32'h0000_0001;
      if (slot_tick_q)
        slot_idx_q <= slot_idx_q + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // led drivers
  // ------------------------------------------------------------
  wire [NUM_TP+2:0] led_o_all;
  wire [NUM_TP+2:0] led_oe_all;

  generate
    for (g = 0; g <= NUM_TP + 2; g = g + 1)
    begin : g_led
      led_driver u_led_driver (
        .clk(clk),
        .rst_n(rst_n),
        .slot_tick(slot_tick_q),
        .slot_idx(slot_idx_q),
        .cond(led_cond[g]),
        .led_o(led_o_all[g]),
        .led_oe(led_oe_all[g])
      );
    end
  endgenerate

  assign twisted_pair_port_led_o = led_o_all[NUM_TP-1:0];
  assign twisted_pair_port_led_oe = led_oe_all[NUM_TP-1:0];
  assign attachment_port_led_o = led_o_all[NUM_TP];
  assign attachment_port_led_oe = led_oe_all[NUM_TP];
  assign common_fault_led_o = led_o_all[NUM_TP+1];
  assign common_fault_led_oe = led_oe_all[NUM_TP+1];
  assign common_activity_led_o = led_o_all[NUM_TP+2];
  assign common_activity_led_oe = led_oe_all[NUM_TP+2];

  // ------------------------------------------------------------
  // events
  // ------------------------------------------------------------
  reg col_prev_q;
  reg fifo_prev_q;
  reg jab_prev_q;
  reg part_prev_q;
  wire [`EV_W-1:0] events;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      col_prev_q <= 1'b0;
      fifo_prev_q <= 1'b0;
      jab_prev_q <= 1'b0;
      part_prev_q <= 1'b0;
    end
    else
    begin
      col_prev_q <= shared_collision;
      fifo_prev_q <= fifo_error;
      jab_prev_q <= jabber_lockup_indication;
      part_prev_q <= |port_partitioned;
    end
  end

  assign events = {(|port_partitioned) && !part_prev_q,
                   jabber_lockup_indication && !jab_prev_q,
                   fifo_error && !fifo_prev_q,
                   shared_collision && !col_prev_q};

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  reg [`EV_W-1:0] status_q;
  reg [`EV_W-1:0] status_d;
  reg [`EV_W-1:0] mask_q;
  reg [`REG_DATA_W-1:0] rdata_d;

  always @*
  begin
    status_d = status_q;
    if (reg_wr && reg_addr == `REG_EVENT_STATUS)
      status_d = status_q & ~reg_wdata[`EV_W-1:0];
    // a new event outranks a clear in the same cycle
    status_d = status_d | events;
  end

  always @*
  begin
    rdata_d = {`REG_DATA_W{1'b0}};
    if (reg_addr == `REG_EVENT_STATUS)
      rdata_d[`EV_W-1:0] = status_q;
    else if (reg_addr == `REG_EVENT_MASK)
      rdata_d[`EV_W-1:0] = mask_q;
    else if (reg_addr == `REG_LIVE_STATE)
      rdata_d[`LIVE_SHARED_COL:0] = {shared_collision, local_collision, mode_valid_q,
                                     led_mode_q};
    else if (reg_addr == `REG_CONTROL)
      rdata_d[`CTRL_W-1:0] = ctrl_q;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_q <= {`EV_W{1'b0}};
      mask_q <= `MASK_RESET;
      ctrl_q <= `CTRL_RESET;
      reg_rdata <= {`REG_DATA_W{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      if (reg_wr && reg_addr == `REG_EVENT_MASK)
        mask_q <= reg_wdata[`EV_W-1:0];
      if (reg_wr && reg_addr == `REG_CONTROL)
        ctrl_q <= reg_wdata[`CTRL_W-1:0];
      reg_rdata <= reg_rd ? rdata_d : {`REG_DATA_W{1'b0}};
      irq <= |(status_d & mask_q);
    end
  end

endmodule

//--- sim/repeater_led_collision_status_properties.sv
// assertions on the collision, backplane and led status ports
`timescale 1ns/100ps
`include "led_collision_regs.vh"
module rlcs_props #(
  parameter NUM_TP = 4
) (
  input wire clk,
  input wire rst_b,
  input wire [NUM_TP:0] port_rx_active,
  input wire attachment_collision_pair,
  input wire backplane_collision_line_i,
  input wire backplane_collision_line_o,
  input wire backplane_collision_line_oe,
  input wire [NUM_TP-1:0] twisted_pair_port_led_oe,
  input wire attachment_port_led_oe,
  input wire common_fault_led_oe,
  input wire common_activity_led_oe,
  input wire local_collision,
  input wire shared_collision,
  input wire reg_rd,
  input wire [`REG_DATA_W-1:0] reg_rdata,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  // line sync is two flops, so three low samples must reach the register
  sequence line_low3;
    !backplane_collision_line_i [*3];
  endsequence
  sequence acp_held3;
    attachment_collision_pair [*3];
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_drain_only: assert property (backplane_collision_line_o == 1'b0)
    else $error("backplane line driven high");
  chk_two_rx: assert property ($countones(port_rx_active) >= 2 |=> local_collision)
    else $error("two receivers gave no collision");
  chk_acp_col: assert property (acp_held3 |=> local_collision)
    else $error("collision pair gave no collision");
  chk_local_cause: assert property (local_collision |->
    $countones($past(port_rx_active)) >= 2 || $past(attachment_collision_pair, 3))
    else $error("collision without cause");
  chk_oe_local: assert property (backplane_collision_line_oe |-> local_collision)
    else $error("line pulled without own collision");
  chk_shared_local: assert property (local_collision |-> shared_collision)
    else $error("own collision not shared");
  chk_shared_line: assert property (line_low3 |=> shared_collision)
    else $error("low backplane line not seen");
  chk_reset_idle: assert property ($rose(rst_b) |-> !(|{twisted_pair_port_led_oe,
    attachment_port_led_oe, common_fault_led_oe, common_activity_led_oe}) && !irq)
    else $error("outputs active out of reset");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule

//--- sim/led_backplane_model.sv
// far side: pulled-up backplane line shared with other repeaters, and the lamps
`timescale 1ns/100ps
module led_backplane_model (
  input wire line_o,
  input wire line_oe,
  input wire other_pull,
  input wire [6:0] led_o,
  input wire [6:0] led_oe,
  output wire line,
  output wire [13:0] led_code
);
  // one pull-up for the whole system: high unless some repeater sinks it
  assign line = ((line_oe && !line_o) || other_pull) ? 1'b0 : 1'b1;
  // lamp code per pin: 0 high z, 1 driven high, 2 driven low
  genvar i;
  generate
    for (i = 0; i < 7; i = i + 1)
    begin : g_lamp
      assign led_code[2*i +: 2] = !led_oe[i] ? 2'h0 : (led_o[i] ? 2'h1 : 2'h2);
    end
  endgenerate
endmodule

//--- sim/tb_repeater_led_collision_status.sv
// self-checking bench for collision, backplane and led status logic
`timescale 1ns/100ps
`include "led_collision_regs.vh"
module tb_repeater_led_collision_status;
  localparam SLOT = 8;
  // expected condition per led (nibble per mode): act, fault, aui, tp3..tp0
  localparam [111:0] TBL = {16'h2222, 16'h1111, 16'h0002, 16'h1111, 16'h0003,
    16'h3205, 16'h2444};
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [4:0] rx_act = 5'h00;
  reg [3:0] link = 4'h0;
  reg [3:0] pol = 4'h0;
  reg [4:0] txp = 5'h00;
  reg [4:0] rxp = 5'h00;
  reg [4:0] part = 5'h00;
  reg fifo = 1'b0;
  reg jab = 1'b0;
  reg acp = 1'b0;
  reg s_hi = 1'b0;
  reg s_lo = 1'b0;
  reg other = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wd = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire [7:0] rdat;
  wire irq, loc, shr, line, line_o, line_oe, aui_o, aui_oe, cf_o, cf_oe, act_o, act_oe;
  wire [3:0] tp_o, tp_oe;
  wire [13:0] code;
  integer bad_count = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer m, i;
  reg [13:0] smp [0:31];
  reg [7:0] d;
  repeater_led_collision_status #(.NUM_TP(4), .SLOT_CYCLES(SLOT)) dut (
    .clk(clk), .rst_b(rst_b), .port_rx_active(rx_act), .tp_link_pulse(link),
    .tp_polarity_reversed(pol), .port_tx_packet(txp), .port_rx_packet(rxp),
    .port_partitioned(part), .fifo_error(fifo), .jabber_lockup_indication(jab),
    .attachment_collision_pair(acp), .led_mode_strap_hi(s_hi), .led_mode_strap_lo(s_lo),
    .backplane_collision_line_i(line), .backplane_collision_line_o(line_o),
    .backplane_collision_line_oe(line_oe), .twisted_pair_port_led_o(tp_o),
    .twisted_pair_port_led_oe(tp_oe), .attachment_port_led_o(aui_o),
    .attachment_port_led_oe(aui_oe), .common_fault_led_o(cf_o), .common_fault_led_oe(cf_oe),
    .common_activity_led_o(act_o), .common_activity_led_oe(act_oe), .local_collision(loc),
    .shared_collision(shr), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdat), .irq(irq));
  led_backplane_model far (.line_o(line_o), .line_oe(line_oe), .other_pull(other),
    .led_o({act_o, cf_o, aui_o, tp_o}), .led_oe({act_oe, cf_oe, aui_oe, tp_oe}),
    .line(line), .led_code(code));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input [7:0] got, input [7:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wreg(input [3:0] a, input [7:0] v);
  begin
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask
  task rreg(input [3:0] a, output [7:0] v);
  begin
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  end
  endtask
  task reset(input [1:0] mo);
  begin
    @(posedge clk);
    rst_b <= 1'b0;
    s_hi <= mo[1];
    s_lo <= mo[0];
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
  end
  endtask
  function [7:0] pat(input integer c);
    case (c)
      1: pat = 8'h11;
      2: pat = 8'h22;
      3: pat = 8'h99;
      4: pat = 8'h05;
      5: pat = 8'h0A;
      default: pat = 8'h00;
    endcase
  endfunction
  // phase of the slot timer is unknown, so accept any rotation of the frame
  task led_chk(input integer n, input integer c);
    integer k, j, ok, hit;
  begin
    hit = 0;
    for (k = 0; k < 4 * SLOT; k = k + 1)
    begin
      ok = 1;
      for (j = 0; j < 4 * SLOT; j = j + 1)
        if ({6'h00, smp[j][2*n +: 2]} !== ((pat(c) >> (2 * (((j + k) / SLOT) % 4))) & 8'h03))
          ok = 0;
      if (ok)
        hit = 1;
    end
    chk(hit ? pat(c) : 8'hFF, pat(c));
  end
  endtask
  task print_verdict;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // ----------------------------------------
  // clock and timeout
  // ----------------------------------------
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      bad_count = bad_count + 1;
      print_verdict;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    for (m = 0; m < 4; m = m + 1)
    begin
      reset(m[1:0]);
      rreg(`REG_LIVE_STATE, d);
      chk(d, {5'h01, m[1:0]});
      rreg(`REG_CONTROL, d);
      chk(d, 8'h03);
      rreg(`REG_EVENT_MASK, d);
      chk(d, 8'h00);
      s_hi <= ~m[1];
      s_lo <= ~m[0];
      rxp <= 5'h01;
      part <= 5'h02;
      pol <= 4'h4;
      link <= 4'h8;
      txp <= 5'h10;
      jab <= (m != 0);
      fifo <= (m == 0);
      repeat (12 * SLOT) @(posedge clk);
      for (i = 0; i < 4 * SLOT; i = i + 1)
      begin
        @(posedge clk);
        #1 smp[i] = code;
      end
      for (i = 0; i < 7; i = i + 1)
        led_chk(i, (TBL >> (16 * i + 4 * m)) & 15);
      rreg(`REG_EVENT_STATUS, d);
      chk(d, m == 0 ? 8'h0A : 8'h0C);
      chk(irq, 1'b0);
      wreg(`REG_EVENT_MASK, 8'h08);
      repeat (2) @(posedge clk);
      #1 chk(irq, 1'b1);
      wreg(`REG_EVENT_STATUS, 8'h0E);
      repeat (2) @(posedge clk);
      #1 chk(irq, 1'b0);
      rreg(`REG_LIVE_STATE, d);
      chk(d, {5'h01, m[1:0]});
      rxp <= 5'h00;
      part <= 5'h00;
      pol <= 4'h0;
      link <= 4'h0;
      txp <= 5'h00;
      jab <= 1'b0;
      fifo <= 1'b0;
    end
    wreg(`REG_EVENT_MASK, 8'h01);
    rx_act <= 5'h01;
    repeat (3) @(posedge clk);
    #1 chk(loc, 1'b0);
    rx_act <= 5'h11;
    repeat (3) @(posedge clk);
    #1 chk({line, loc, shr, irq, line_oe}, 8'h0F);
    rx_act <= 5'h00;
    rreg(`REG_EVENT_STATUS, d);
    chk(d, 8'h01);
    repeat (6) @(posedge clk);
    wreg(`REG_EVENT_STATUS, 8'h01);
    rreg(`REG_EVENT_STATUS, d);
    chk({d[3:0], irq}, 8'h00);
    acp <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk({loc, line}, 8'h02);
    acp <= 1'b0;
    other <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk({shr, loc, line_oe}, 8'h04);
    other <= 1'b0;
    wreg(`REG_CONTROL, 8'h01);
    rx_act <= 5'h03;
    repeat (3) @(posedge clk);
    #1 chk({loc, line_oe, line}, 8'h05);
    rx_act <= 5'h00;
    wreg(4'h2, 8'hFF);
    rreg(4'h2, d);
    chk(d, 8'h00);
    repeat (6) @(posedge clk);
    wreg(`REG_LIVE_STATE, 8'hFF);
    rreg(`REG_LIVE_STATE, d);
    chk(d, 8'h07);
    print_verdict;
  end
endmodule
bind repeater_led_collision_status rlcs_props #(.NUM_TP(NUM_TP)) props (
  .clk(clk), .rst_b(rst_b), .port_rx_active(port_rx_active),
  .attachment_collision_pair(attachment_collision_pair),
  .backplane_collision_line_i(backplane_collision_line_i),
  .backplane_collision_line_o(backplane_collision_line_o),
  .backplane_collision_line_oe(backplane_collision_line_oe),
  .twisted_pair_port_led_oe(twisted_pair_port_led_oe),
  .attachment_port_led_oe(attachment_port_led_oe), .common_fault_led_oe(common_fault_led_oe),
  .common_activity_led_oe(common_activity_led_oe), .local_collision(local_collision),
  .shared_collision(shared_collision), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
